// [verilog/comp_filter_pkg.sv]
`default_nettype none
package comp_filter_pkg;

	// Sample and coefficient width, values are signed Q1.15 except the unsigned 8-bit gain bytes
	localparam int DATA_W   = 16;
	localparam int ACC_W    = 40;
	localparam int Q_FRAC   = 15;
	localparam int GAIN_FRAC = 7;
	localparam int FIFO_DEPTH = 8;
	localparam logic signed [DATA_W-1:0] Q_MAX = 16'sh7fff;
	localparam logic signed [DATA_W-1:0] Q_MIN = -16'sh8000;

	// Configuration byte store: 32 polynomial bytes then gain, offset, filter, clamp
	localparam int NUM_CFG       = 54;
	localparam int CFG_IDX_W     = 6;
	localparam int POLY_STRIDE   = 8;
	localparam int IDX_P_GAIN    = 32;
	localparam int IDX_T_GAIN    = 33;
	localparam int IDX_P_OFS     = 34;
	localparam int IDX_T_OFS     = 36;
	localparam int IDX_A0        = 38;
	localparam int IDX_A1        = 40;
	localparam int IDX_A2        = 42;
	localparam int IDX_B0        = 44;
	localparam int IDX_B1        = 46;
	localparam int IDX_B2        = 48;
	localparam int IDX_CLAMP_LO  = 50;
	localparam int IDX_CLAMP_HI  = 52;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// Address of each configuration byte, in byte-index order
	localparam logic [31:0] CFG_ADDR [NUM_CFG] = '{
		32'h4000000, 32'h40000001, 32'h40000002, 32'h40000003,
		32'h40000004, 32'h40000005, 32'h40000006, 32'h4000007,
		32'h4000008, 32'h40000009, 32'h4000000a, 32'h4000000b,
		32'h4000000c, 32'h400000d, 32'h4000003e, 32'h4000003f,
		32'h40000010, 32'h40000011, 32'h40000012, 32'h40000013,
		32'h40000014, 32'h40000015, 32'h40000016, 32'h40000017,
		32'h40000018, 32'h40000019, 32'h4000001a, 32'h4000001b,
		32'h4000001c, 32'h4000001d, 32'h4000001e, 32'h4000001f,
		32'h40000020, 32'h40000021, 32'h40000022, 32'h40000023,
		32'h40000024, 32'h40000025, 32'h40000040, 32'h4000002b,
		32'h4000002c, 32'h4000002d, 32'h4000002e, 32'h40000041,
		32'h40000042, 32'h40000043, 32'h40000044, 32'h40000045,
		32'h40000046, 32'h40000047, 32'h40000048, 32'h40000049,
		32'h4000004a, 32'h4000004b
	};
	localparam logic [31:0] COMM_BUF_ADDR = 32'h40000080;
	localparam logic [31:0] STATUS_ADDR   = 32'h40000081;

	// Status byte layout
	localparam int ST_BIT_RUN     = 0;
	localparam int ST_BIT_BUSY    = 1;
	localparam int ST_BIT_OVERRUN = 2;

	typedef struct packed {
		logic signed [DATA_W-1:0] pres;
		logic signed [DATA_W-1:0] temp;
	} adc_pair_t;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [7:0]  wdata;
	} mem_req_t;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_POLY   = 5'b00010,
		ST_CLAMP  = 5'b00100,
		ST_FILT_W = 5'b01000,
		ST_FILT_Y = 5'b10000
	} proc_state_t;

endpackage
`default_nettype wire

// [verilog/sample_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	wire              push;
	wire              pop;

	// Full and empty come straight from the occupancy count
	assign in_ready  = (count_reg != CNT_W'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	// Storage array, written only on an accepted push
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers wrap at DEPTH so non-power-of-two depths also work
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
		end
	end
endmodule
`default_nettype wire

// [verilog/sensor_compensation_filter.sv]
// Contract
// - Corrected pressure is the pressure ADC code plus its offset, times its gain.
// - Corrected temperature is the temperature ADC code plus its own offset, times its own gain.
// - Output is the sum over P^0..P^3 of each power times its own cubic polynomial in T.
// - The compensated output is limited between programmable low and high clamps before filtering.
// - Filter state is a0 times clamped output plus a1, a2 times the two previous states.
// - Filtered result is b0, b1, b2 times current and two previous states, stored in the result.
// - In Running mode configuration memory access is refused.
// - In Running mode only the communication buffer is served to the host.
// - In Reset mode the host may read and write configuration memory.
// - In Reset mode the processing logic is held in reset and produces no output.
`timescale 1ns/100ps
`default_nettype none
module sensor_compensation_filter
	import comp_filter_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     run_mode,
	input  wire logic signed [DATA_W-1:0] pressure_adc_code,
	input  wire logic signed [DATA_W-1:0] temperature_adc_code,
	input  wire logic                     adc_valid,
	output logic                          adc_ready,
	input  wire logic                     acc_valid,
	input  wire mem_req_t                 acc_req,
	output logic                          acc_ack,
	output logic                          acc_refused,
	output logic [7:0]                    acc_rdata,
	output logic [7:0]                    host_comm_buffer,
	input  wire logic [7:0]               comm_tx_data,
	output logic signed [DATA_W-1:0]      filtered_result,
	output logic                          result_valid,
	output logic                          busy
);

	// Processing reset: held whenever the device is out of Running mode
	wire proc_rst;
	assign proc_rst = rst | ~run_mode;

	// ---------------- Saturating fixed-point helpers ----------------

	// Clip a wide signed value into Q1.15
	function automatic logic signed [DATA_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] hi;
		logic signed [ACC_W-1:0] lo;
		hi = ACC_W'(Q_MAX);
		lo = ACC_W'(Q_MIN);
		if (v > hi) begin
			sat16 = Q_MAX;
		end else if (v < lo) begin
			sat16 = Q_MIN;
		end else begin
			sat16 = v[DATA_W-1:0];
		end
	endfunction

	// One Horner step: acc * x + add, all Q1.15
	function automatic logic signed [DATA_W-1:0] mac(input logic signed [DATA_W-1:0] acc,
			input logic signed [DATA_W-1:0] x, input logic signed [DATA_W-1:0] add);
		logic signed [ACC_W-1:0] prod;
		prod = ACC_W'(acc) * ACC_W'(x);
		mac = sat16((prod >>> Q_FRAC) + ACC_W'(add));
	endfunction

	// Digital gain and offset: gain is unsigned with GAIN_FRAC fraction bits
	function automatic logic signed [DATA_W-1:0] scale(input logic signed [DATA_W-1:0] code,
			input logic signed [DATA_W-1:0] ofs, input logic [7:0] gain);
		logic signed [ACC_W-1:0] sum;
		logic signed [ACC_W-1:0] g;
		sum = ACC_W'(code) + ACC_W'(ofs);
		g = ACC_W'($signed({1'b0, gain}));
		scale = sat16((sum * g) >>> GAIN_FRAC);
	endfunction

	// Three-tap weighted sum used by both filter equations
	function automatic logic signed [DATA_W-1:0] tap3(
			input logic signed [DATA_W-1:0] c0, input logic signed [DATA_W-1:0] x0,
			input logic signed [DATA_W-1:0] c1, input logic signed [DATA_W-1:0] x1,
			input logic signed [DATA_W-1:0] c2, input logic signed [DATA_W-1:0] x2);
		logic signed [ACC_W-1:0] s;
		s = ACC_W'(c0) * ACC_W'(x0) + ACC_W'(c1) * ACC_W'(x1) + ACC_W'(c2) * ACC_W'(x2);
		tap3 = sat16(s >>> Q_FRAC);
	endfunction

	// ---------------- Configuration memory and host access ----------------

	logic [7:0]           cfg_mem_reg [NUM_CFG];
	logic [NUM_CFG-1:0]   cfg_hit;
	logic [CFG_IDX_W-1:0] hit_idx;
	wire                  cfg_hit_any;
	wire                  comm_buf_hit;
	wire                  status_hit;
	wire                  cfg_allowed;
	wire                  status_allowed;
	wire                  comb_allowed;
	wire                  acc_refuse;
	wire                  status_read;
	wire [7:0]            status_byte;
	wire [7:0]            rdata_next;
	logic                 overrun_reg;
	logic                 overrun_next;

	// Address decode, one comparator per configuration byte
	genvar gi;
	for (gi = 0; gi < NUM_CFG; gi++) begin : g_dec
		assign cfg_hit[gi] = (acc_req.addr == CFG_ADDR[gi]);
	end

	// Encode the single hit into a byte index
	always_comb begin
		hit_idx = '0;
		for (int i = 0; i < NUM_CFG; i++) begin
			if (cfg_hit[i]) begin
				hit_idx = CFG_IDX_W'(i);
			end
		end
	end

	// Memory space is open only in Reset mode; the buffer is open in both modes
	assign cfg_hit_any    = |cfg_hit;
	assign comm_buf_hit   = (acc_req.addr == COMM_BUF_ADDR);
	assign status_hit     = (acc_req.addr == STATUS_ADDR);
	assign cfg_allowed    = acc_valid & cfg_hit_any & ~run_mode;
	assign status_allowed = acc_valid & status_hit & ~run_mode;
	assign comb_allowed   = acc_valid & comm_buf_hit;
	assign acc_refuse     = acc_valid & ~cfg_allowed & ~status_allowed & ~comb_allowed;
	assign status_read    = status_allowed & ~acc_req.we;

	// Read data selection; writes to the status byte are accepted but ignored
	assign status_byte = {5'h00, overrun_reg, busy, run_mode};
	assign rdata_next  = cfg_allowed    ? cfg_mem_reg[hit_idx] :
			     status_allowed ? status_byte :
			     comb_allowed   ? comm_tx_data : 8'h00;

	// Configuration bytes keep their values across mode changes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_CFG; i++) begin
				cfg_mem_reg[i] <= CFG_RESET;
			end
		end else if (cfg_allowed & acc_req.we) begin
			cfg_mem_reg[hit_idx] <= acc_req.wdata;
		end
	end

	// Access answer one cycle after the request, with registered read data
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_ack          <= 1'b0;
			acc_refused      <= 1'b0;
			acc_rdata        <= 8'h00;
			host_comm_buffer <= 8'h00;
		end else begin
			acc_ack     <= acc_valid & ~acc_refuse;
			acc_refused <= acc_refuse;
			acc_rdata   <= rdata_next;
			if (comb_allowed & acc_req.we) begin
				host_comm_buffer <= acc_req.wdata;
			end
		end
	end

	// Assemble a 16-bit coefficient from its low and high byte
	function automatic logic signed [DATA_W-1:0] coef16(input int base);
		coef16 = {cfg_mem_reg[base + 1], cfg_mem_reg[base]};
	endfunction

	// Polynomial coefficient k (power of P), j (power of T)
	function automatic logic signed [DATA_W-1:0] poly_coef(input logic [1:0] k,
			input logic [1:0] j);
		poly_coef = coef16(int'(k) * POLY_STRIDE + int'(j) * 2);
	endfunction

	// ---------------- Sample buffer ----------------

	adc_pair_t fifo_in;
	adc_pair_t fifo_out;
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire       fifo_pop;

	assign fifo_in.pres = pressure_adc_code;
	assign fifo_in.temp = temperature_adc_code;
	// No new samples are taken outside Running mode
	assign adc_ready    = fifo_in_ready & run_mode;

	sample_fifo #(
		.WIDTH ($bits(adc_pair_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (proc_rst),
		.in_valid  (adc_valid & run_mode),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out)
	);

	// Overrun: a sample offered while the buffer is full; set wins over the status read clear
	assign overrun_next = (adc_valid & run_mode & ~fifo_in_ready) | (overrun_reg & ~status_read);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overrun_reg <= 1'b0;
		end else begin
			overrun_reg <= overrun_next;
		end
	end

	// ---------------- Compensation and filter sequencer ----------------

	proc_state_t              state_reg;
	proc_state_t              state_next;
	logic signed [DATA_W-1:0] pres_reg;
	logic signed [DATA_W-1:0] temp_reg;
	logic signed [DATA_W-1:0] poly_acc_reg;
	logic signed [DATA_W-1:0] out_acc_reg;
	logic signed [DATA_W-1:0] clamped_reg;
	logic signed [DATA_W-1:0] w0_reg;
	logic signed [DATA_W-1:0] w1_reg;
	logic signed [DATA_W-1:0] w2_reg;
	logic [1:0]               k_reg;
	logic [1:0]               j_reg;
	wire signed [DATA_W-1:0]  pres_scaled;
	wire signed [DATA_W-1:0]  temp_scaled;
	wire signed [DATA_W-1:0]  poly_step;
	wire signed [DATA_W-1:0]  out_step;
	wire signed [DATA_W-1:0]  clamp_lo;
	wire signed [DATA_W-1:0]  clamp_hi;
	wire signed [DATA_W-1:0]  clamp_val;
	wire signed [DATA_W-1:0]  w_new;
	wire signed [DATA_W-1:0]  y_new;
	wire                      poly_last_t;
	wire                      poly_last_p;
	wire [CFG_IDX_W-1:0]      poly_idx;
	wire signed [DATA_W-1:0]  poly_c;

	// A new pair is taken only when the previous pass is fully finished
	assign fifo_pop = (state_reg == ST_IDLE) & fifo_out_valid;
	assign busy     = (state_reg != ST_IDLE);

	// Gain and offset applied as the pair leaves the buffer
	assign pres_scaled = scale(fifo_out.pres, coef16(IDX_P_OFS), cfg_mem_reg[IDX_P_GAIN]);
	assign temp_scaled = scale(fifo_out.temp, coef16(IDX_T_OFS), cfg_mem_reg[IDX_T_GAIN]);

	// Horner in T for the current polynomial, then Horner in P across the four
	// Coefficient bytes are direct operands so the wire follows every byte write
	assign poly_idx    = CFG_IDX_W'(int'(k_reg) * POLY_STRIDE + int'(j_reg) * 2);
	assign poly_c      = {cfg_mem_reg[poly_idx + 1'b1], cfg_mem_reg[poly_idx]};
	assign poly_step   = mac(poly_acc_reg, temp_reg, poly_c);
	assign out_step    = mac(out_acc_reg, pres_reg, poly_step);
	assign poly_last_t = (j_reg == 2'd0);
	assign poly_last_p = (k_reg == 2'd0);

	// Clamp limits read straight from the bytes; a low limit above the high one gives high above high and low for all other values
	assign clamp_lo  = {cfg_mem_reg[IDX_CLAMP_LO + 1], cfg_mem_reg[IDX_CLAMP_LO]};
	assign clamp_hi  = {cfg_mem_reg[IDX_CLAMP_HI + 1], cfg_mem_reg[IDX_CLAMP_HI]};
	assign clamp_val = (out_acc_reg > clamp_hi) ? clamp_hi :
			   (out_acc_reg < clamp_lo) ? clamp_lo : out_acc_reg;

	// Second-order filter equations
	assign w_new = tap3(coef16(IDX_A0), clamped_reg, coef16(IDX_A1), w1_reg,
			    coef16(IDX_A2), w2_reg);
	assign y_new = tap3(coef16(IDX_B0), w0_reg, coef16(IDX_B1), w1_reg,
			    coef16(IDX_B2), w2_reg);

	// Next state: poly, clamp, filter state, filter output, in that order
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (fifo_out_valid) begin
					state_next = ST_POLY;
				end
			end
			ST_POLY: begin
				if (poly_last_t & poly_last_p) begin
					state_next = ST_CLAMP;
				end
			end
			ST_CLAMP:  state_next = ST_FILT_W;
			ST_FILT_W: state_next = ST_FILT_Y;
			ST_FILT_Y: state_next = ST_IDLE;
			default:   state_next = ST_IDLE;
		endcase
	end

	// Held in reset outside Running mode, so no pass starts and no result appears
	always_ff @(posedge sys_clk) begin
		if (proc_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Polynomial evaluation: the highest power of P starts, out_acc begins at zero
	always_ff @(posedge sys_clk) begin
		if (proc_rst) begin
			pres_reg     <= '0;
			temp_reg     <= '0;
			poly_acc_reg <= '0;
			out_acc_reg  <= '0;
			k_reg        <= 2'd3;
			j_reg        <= 2'd2;
		end else if (fifo_pop) begin
			pres_reg     <= pres_scaled;
			temp_reg     <= temp_scaled;
			poly_acc_reg <= poly_coef(2'd3, 2'd3);
			out_acc_reg  <= '0;
			k_reg        <= 2'd3;
			j_reg        <= 2'd2;
		end else if (state_reg == ST_POLY) begin
			if (poly_last_t) begin
				out_acc_reg  <= out_step;
				k_reg        <= k_reg - 2'd1;
				j_reg        <= 2'd2;
				poly_acc_reg <= poly_coef(k_reg - 2'd1, 2'd3);
			end else begin
				poly_acc_reg <= poly_step;
				j_reg        <= j_reg - 2'd1;
			end
		end
	end

	// Clamp stage and filter history; history shifts once per finished sample
	always_ff @(posedge sys_clk) begin
		if (proc_rst) begin
			clamped_reg <= '0;
			w0_reg      <= '0;
			w1_reg      <= '0;
			w2_reg      <= '0;
		end else begin
			if (state_reg == ST_CLAMP) begin
				clamped_reg <= clamp_val;
			end
			if (state_reg == ST_FILT_W) begin
				w0_reg <= w_new;
			end
			if (state_reg == ST_FILT_Y) begin
				w1_reg <= w0_reg;
				w2_reg <= w1_reg;
			end
		end
	end

	// In Running mode the output register keeps its last value until the next finished pass
	always_ff @(posedge sys_clk) begin
		if (proc_rst) begin
			filtered_result <= '0;
			result_valid    <= 1'b0;
		end else begin
			result_valid <= (state_reg == ST_FILT_Y);
			if (state_reg == ST_FILT_Y) begin
				filtered_result <= y_new;
			end
		end
	end

endmodule
`default_nettype wire

// [verif/sensor_compensation_filter_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module sensor_compensation_filter_sva
	import comp_filter_pkg::*;
(
	input wire logic                     sys_clk,
	input wire logic                     rst,
	input wire logic                     run_mode,
	input wire logic                     adc_valid,
	input wire logic                     adc_ready,
	input wire logic                     acc_valid,
	input wire mem_req_t                 acc_req,
	input wire logic                     acc_ack,
	input wire logic                     acc_refused,
	input wire logic [7:0]               acc_rdata,
	input wire logic [7:0]               host_comm_buffer,
	input wire logic [7:0]               comm_tx_data,
	input wire logic signed [DATA_W-1:0] filtered_result,
	input wire logic                     result_valid,
	input wire logic                     busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Address decode seen by the host side
	wire logic cfg_hit = acc_req.addr inside {CFG_ADDR};
	wire logic is_comb = acc_req.addr == COMM_BUF_ADDR;
	// A pass is fifteen busy cycles, then the result pulse with busy low
	sequence s_run; busy[*8] ##1 busy[*7]; endsequence
	sequence s_done; !busy && result_valid; endsequence
	property p_one_answer; acc_valid |=> acc_ack ^ acc_refused; endproperty
	a_one_answer: assert property (p_one_answer) else $error("access not answered once");
	property p_quiet; !acc_valid |=> !(acc_ack || acc_refused); endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_run_refuse; acc_valid && run_mode && !is_comb |=> acc_refused; endproperty
	a_run_refuse: assert property (p_run_refuse) else $error("memory served while running");
	property p_cfg_serve; acc_valid && !run_mode && cfg_hit |=> acc_ack; endproperty
	a_cfg_serve: assert property (p_cfg_serve) else $error("config refused in reset mode");
	property p_comb_wr;
		acc_valid && is_comb && acc_req.we |=> acc_ack && host_comm_buffer == $past(acc_req.wdata);
	endproperty
	a_comb_wr: assert property (p_comb_wr) else $error("buffer write lost");
	property p_comb_rd;
		acc_valid && is_comb && !acc_req.we |=> acc_ack && acc_rdata == $past(comm_tx_data);
	endproperty
	a_comb_rd: assert property (p_comb_rd) else $error("buffer read wrong");
	property p_halt;
		!run_mode |-> !adc_ready ##1 (!result_valid && !busy && filtered_result == 0);
	endproperty
	a_halt: assert property (p_halt) else $error("processing active in reset mode");
	property p_pass; disable iff (rst || !run_mode) $rose(busy) |-> s_run ##1 s_done; endproperty
	a_pass: assert property (p_pass) else $error("pass length wrong");
	property p_hold;
		run_mode && $past(run_mode) && !result_valid |-> $stable(filtered_result);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved without pulse");
	c_full: cover property (run_mode && adc_valid && !adc_ready);
endmodule
`default_nettype wire

// [verif/adc_model.sv]
`timescale 1ns/100ps
`default_nettype none
module adc_model
	import comp_filter_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                go,
	input  wire logic                fast,
	input  wire logic                adc_ready,
	output logic                     adc_valid,
	output logic signed [DATA_W-1:0] pres,
	output logic signed [DATA_W-1:0] temp
);
	int seed = 32'h5456cdab;
	initial begin
		adc_valid = 1'b0;
		pres = '0;
		temp = '0;
	end
	// Offered pair holds until taken or go drops; idle lines toggle so stale data never passes as valid
	always @(posedge sys_clk) begin
		if (rst) begin
			adc_valid <= 1'b0;
		end else if (adc_valid && !adc_ready && go) begin
			adc_valid <= 1'b1;
		end else if (go && (fast || ($random(seed) & 3) == 0)) begin
			adc_valid <= 1'b1;
			pres <= 16'($random(seed) % 8192);
			temp <= 16'($random(seed) % 8192);
		end else begin
			adc_valid <= 1'b0;
			pres <= ~pres;
			temp <= ~temp;
		end
	end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
	import comp_filter_pkg::*;
();
	localparam int PG = 96, TG = 128, POF = 256, TOF = -64, H0 = 2048, H1 = 8192, G0 = 24576;
	localparam int A0 = 16384, A1 = 8192, A2 = 4096, B0 = 16384, B1 = 4096, B2 = 2048;
	localparam int CLO = -4096, CHI = 6144;
	localparam int CI [14] = '{0, 2, POLY_STRIDE, IDX_P_GAIN, IDX_P_OFS, IDX_T_OFS, IDX_A0,
		IDX_A1, IDX_A2, IDX_B0, IDX_B1, IDX_B2, IDX_CLAMP_LO, IDX_CLAMP_HI};
	localparam int CV [14] = '{H0, H1, G0, TG * 256 + PG, POF, TOF, A0, A1, A2, B0, B1, B2,
		CLO, CHI};
	logic                     sys_clk, rst, run_mode, acc_valid, go, fast;
	mem_req_t                 acc_req;
	logic [7:0]               comm_tx_data;
	wire logic                adc_valid, adc_ready, acc_ack, acc_refused, result_valid, busy;
	wire logic [7:0]          acc_rdata, host_comm_buffer;
	wire logic signed [15:0]  pres, temp, filtered_result;
	int                       err_count, checks, seed, w1, w2, i;
	logic [16:0]              q_acc [$], q_res [$];
	logic [7:0]               bval;

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	sensor_compensation_filter #(.DEPTH(FIFO_DEPTH)) i_dut (.sys_clk, .rst, .run_mode,
		.pressure_adc_code(pres), .temperature_adc_code(temp), .adc_valid, .adc_ready,
		.acc_valid, .acc_req, .acc_ack, .acc_refused, .acc_rdata, .host_comm_buffer,
		.comm_tx_data, .filtered_result, .result_valid, .busy);
	adc_model i_adc (.sys_clk, .rst, .go, .fast, .adc_ready, .adc_valid, .pres, .temp);

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (err_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One request per cycle; e is {refused, read data} expected next cycle
	task automatic acc(input logic we, input logic [31:0] a, input logic [7:0] d,
		input logic [8:0] e);
		@(posedge sys_clk);
		acc_valid <= 1'b1;
		acc_req <= '{we, a, d};
		q_acc.push_back({8'h00, e});
	endtask

	task automatic w16(input int idx, input logic [15:0] v);
		acc(1'b1, CFG_ADDR[idx], v[7:0], 9'h000);
		acc(1'b1, CFG_ADDR[idx + 1], v[15:8], 9'h000);
	endtask

	task automatic drain;
		for (int k = 0; k < 600 && q_res.size() > 0; k++) @(posedge sys_clk);
		chk(17'(q_res.size()), 17'h0);
	endtask

	// Reference arithmetic in arrival order; only h0, h1, g0 are nonzero, so Horner is exact
	function automatic void note(input int p, input int t);
		int pp, tt, x, w;
		pp = ((p + POF) * PG) >>> 7;
		tt = ((t + TOF) * TG) >>> 7;
		x = H0 + ((H1 * tt) >>> 15) + ((G0 * pp) >>> 15);
		x = x > CHI ? CHI : (x < CLO ? CLO : x);
		w = (A0 * x + A1 * w1 + A2 * w2) >>> 15;
		q_res.push_back({1'b0, 16'((B0 * w + B1 * w1 + B2 * w2) >>> 15)});
		w2 = w1;
		w1 = w;
	endfunction

	// Watcher: takes note of accepted pairs, compares every result with the oldest note and every answer with the oldest request
	always @(posedge sys_clk) begin
		if (adc_valid && adc_ready) note(pres, temp);
		if (acc_ack || acc_refused)
			chk({8'h00, acc_refused, acc_rdata}, q_acc.size() ? q_acc.pop_front() : 17'h1ffff);
		if (result_valid)
			chk({1'b0, filtered_result}, q_res.size() ? q_res.pop_front() : 17'h1ffff);
	end

	initial begin
		repeat (8000) @(posedge sys_clk);
		err_count++;
		final_report();
	end

	initial begin
		seed = 32'h5456cdab;
		rst = 1'b1;
		run_mode = 1'b0;
		acc_valid = 1'b0;
		acc_req = '0;
		go = 1'b0;
		fast = 1'b0;
		comm_tx_data = 8'($random(seed));
		err_count = 0;
		checks = 0;
		w1 = 0;
		w2 = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		// Reset values, then read back and clear every configuration byte
		for (i = 0; i < NUM_CFG; i++) acc(1'b0, CFG_ADDR[i], 8'h00, {1'b0, CFG_RESET});
		for (i = 0; i < NUM_CFG; i++) begin
			bval = 8'($random(seed));
			acc(1'b1, CFG_ADDR[i], bval, 9'h000);
			acc(1'b0, CFG_ADDR[i], 8'h00, {1'b0, bval});
			acc(1'b1, CFG_ADDR[i], 8'h00, {1'b0, bval});
		end
		acc(1'b0, 32'h40000030, 8'h00, 9'h100);
		acc(1'b1, STATUS_ADDR, 8'hff, 9'h000);
		acc(1'b0, STATUS_ADDR, 8'h00, 9'h000);
		acc(1'b1, COMM_BUF_ADDR, 8'h5a, {1'b0, comm_tx_data});
		acc(1'b0, COMM_BUF_ADDR, 8'h00, {1'b0, comm_tx_data});
		for (i = 0; i < 14; i++) w16(CI[i], 16'(CV[i]));
		@(posedge sys_clk);
		acc_valid <= 1'b0;
		run_mode <= 1'b1;
		// Running mode: only the communication buffer is served
		acc(1'b0, CFG_ADDR[IDX_A0], 8'h00, 9'h100);
		acc(1'b1, CFG_ADDR[IDX_B0], 8'h77, 9'h100);
		acc(1'b0, STATUS_ADDR, 8'h00, 9'h100);
		acc(1'b0, COMM_BUF_ADDR, 8'h00, {1'b0, comm_tx_data});
		@(posedge sys_clk);
		acc_valid <= 1'b0;
		go <= 1'b1;
		// Slow offers, then a burst that fills the buffer until it refuses
		repeat (200) @(posedge sys_clk);
		fast <= 1'b1;
		for (i = 0; i < 100 && adc_ready !== 1'b0; i++) @(posedge sys_clk);
		chk({16'h0, adc_ready}, 17'h0);
		go <= 1'b0;
		drain();
		// Leaving Running mode mid-pass drops pending pairs and filter history
		fast <= 1'b0;
		go <= 1'b1;
		repeat (40) @(posedge sys_clk);
		run_mode <= 1'b0;
		go <= 1'b0;
		@(posedge sys_clk);
		#1;
		q_res.delete();
		w1 = 0;
		w2 = 0;
		repeat (20) @(posedge sys_clk);
		// Sticky overrun from the burst shows once, then the served read clears it
		acc(1'b0, STATUS_ADDR, 8'h00, 9'h004);
		acc(1'b0, STATUS_ADDR, 8'h00, 9'h000);
		acc(1'b0, CFG_ADDR[IDX_B0], 8'h00, 9'h000);
		@(posedge sys_clk);
		acc_valid <= 1'b0;
		run_mode <= 1'b1;
		go <= 1'b1;
		repeat (150) @(posedge sys_clk);
		go <= 1'b0;
		drain();
		final_report();
	end
endmodule

bind sensor_compensation_filter sensor_compensation_filter_sva i_sva (.sys_clk, .rst, .run_mode,
	.adc_valid, .adc_ready, .acc_valid, .acc_req, .acc_ack, .acc_refused, .acc_rdata,
	.host_comm_buffer, .comm_tx_data, .filtered_result, .result_valid, .busy);
`default_nettype wire
